//--- dsism_pkg.sv
/*
  Package for the drive speed / increment safety monitor: widths, timing
  constants, default configuration values, carrier structs and states.
  Assumes one 20 MHz clock shared by the encoder evaluation, the safe
  application request logic and this monitor.
*/
package dsism_pkg;

  localparam int DATA_WIDTH = 32;
  localparam int LIMIT_COUNT = 4;

  localparam int CLK_PERIOD_NS = 50;
  localparam int NS_PER_US = 1000;
  localparam int CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;

  // Default configuration values
  localparam logic DEFAULT_RAMP_MONITOR_ENABLE = 1'b1;
  localparam logic DEFAULT_MAX_SPEED_USED = 1'b1;
  localparam logic [31:0] DEFAULT_MAX_SPEED_LIMIT = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_SPEED_LIMIT = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_MONITOR_TIME_US = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_REQUEST_DELAY_US = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_STANDSTILL_TOLERANCE = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_INCREMENT_SIZE = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_OFF_DELAY_US = 32'h0000_0000;

  // Reset values of registered state
  localparam logic RESET_FAIL_SAFE = 1'b0;
  localparam logic [31:0] RESET_ORIGIN = 32'h0000_0000;

  typedef struct packed {
    logic ramp_monitor_enable;
    logic max_speed_used;
    logic [31:0] max_speed_limit;
    logic [LIMIT_COUNT-1:0][31:0] speed_limit;
    logic [LIMIT_COUNT-1:0][31:0] monitor_time_us;
    logic [31:0] request_delay_us;
    logic [31:0] standstill_tolerance;
    logic [31:0] increment_size;
    logic [31:0] off_delay_us;
  } dsism_config_type;

  typedef struct packed {
    logic signed [31:0] speed;
    logic signed [31:0] position;
    logic present;
    logic fault;
  } dsism_encoder_type;

  typedef struct packed {
    logic limited_speed_request;
    logic [1:0] limit_select;
    logic increment_request;
    logic error_ack;
  } dsism_request_type;

  typedef struct packed {
    logic limited_speed_safe;
    logic max_speed_safe;
    logic increment_safe;
    logic function_no_error_out;
    logic torque_enable;
    logic fail_safe;
  } dsism_status_type;

  typedef enum logic [1:0] {
    SLS_IDLE,
    SLS_DELAY,
    SLS_MONITOR_TIME,
    SLS_ENFORCE
  } dsism_sls_state_type;

  typedef enum logic [1:0] {
    SLI_IDLE,
    SLI_ACTIVE,
    SLI_OFF_DELAY
  } dsism_sli_state_type;

endpackage : dsism_pkg

//--- dsism_us_timer.sv
/*
  Microsecond countdown timer. A load restarts both the microsecond count
  and the sub-microsecond prescaler, so the time runs from the load edge.
  Assumes the load value is stable only in the load cycle.
*/
`timescale 1ns/1ps
module dsism_us_timer
  import dsism_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic load, // Restart the timer
  input wire logic [31:0] load_us, // Time to run, microseconds
  output logic done // Time has elapsed
);

  localparam logic [4:0] PRESCALE_LAST = 5'(CYCLES_PER_US - 1);

  logic [31:0] remaining;
  logic [4:0] prescale;
  logic [31:0] next_remaining;
  logic [4:0] next_prescale;

  always_comb begin
    next_remaining = remaining;
    next_prescale = prescale;
    if (load) begin
      next_remaining = load_us;
      next_prescale = 5'h00;
    end else if (remaining != 32'h0000_0000) begin
      if (prescale == PRESCALE_LAST) begin
        next_prescale = 5'h00;
        next_remaining = remaining - 32'h0000_0001;
      end else begin
        next_prescale = prescale + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      remaining <= 32'h0000_0000;
      prescale <= 5'h00;
    end else if (ce) begin
      remaining <= next_remaining;
      prescale <= next_prescale;
    end
  end

  assign done = (remaining == 32'h0000_0000);

endmodule : dsism_us_timer

//--- dsism_abs_compare.sv
/*
  Magnitude comparator: flags a signed value whose magnitude exceeds an
  unsigned limit. Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module dsism_abs_compare #(
  parameter int WIDTH = 32
) (
  input wire logic signed [WIDTH-1:0] value, // Signed quantity
  input wire logic [31:0] limit, // Unsigned magnitude limit
  output logic exceeds // Magnitude above limit
);

  logic [WIDTH:0] magnitude;

  // One extra bit keeps the most negative value's magnitude exact
  always_comb begin
    if (value[WIDTH-1]) begin
      magnitude = (WIDTH+1)'(-$signed({value[WIDTH-1], value}));
    end else begin
      magnitude = {1'b0, value};
    end
  end

  assign exceeds = (magnitude > (WIDTH+1)'(limit));

endmodule : dsism_abs_compare

//--- dsism_monitor.sv
/*
  Top of the drive speed / increment safety monitor: limited-speed
  function in time-supervised stopping, switchable maximum-speed check and
  limited-increment position window with switch-off delay, plus the
  latched functional fail-safe state.
  Assumes encoder data and requests come from logic on the same clock, and
  that the drive application performs the stopping motion itself.
*/
`timescale 1ns/1ps
module dsism_monitor
  import dsism_pkg::*;
(
  input wire logic clk, // System clock, 20 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire dsism_config_type config_in, // Safety parameters
  input wire dsism_encoder_type encoder, // Safe encoder feedback
  input wire dsism_request_type request, // Requests from safe application
  output dsism_status_type status // Safe-state bits and error state
);

  // Limited-speed state
  dsism_sls_state_type sls_state;
  dsism_sls_state_type next_sls_state;
  logic [1:0] sls_select;
  logic [1:0] next_sls_select;
  logic [1:0] sls_limit_index;
  logic sls_timer_load;
  logic [31:0] sls_timer_value;
  logic sls_timer_done;

  // Limited-increment state
  dsism_sli_state_type sli_state;
  dsism_sli_state_type next_sli_state;
  logic signed [31:0] origin;
  logic signed [31:0] next_origin;
  logic sli_timer_load;
  logic sli_timer_done;

  // Error state
  logic fail_safe;
  logic next_fail_safe;
  logic ack_prev;
  logic next_ack_prev;
  dsism_status_type next_status;

  // Comparator results
  logic sls_over;
  logic sms_over;
  logic standstill_over;
  logic window_over;
  logic signed [32:0] travel;
  logic encoder_bad;
  logic sls_violation;
  logic sms_violation;
  logic sli_violation;
  logic any_violation;
  logic ack_edge;

  assign encoder_bad = !encoder.present || encoder.fault;

  // Limited-speed timer: request delay then monitoring time
  dsism_us_timer u_sls_timer (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .load(sls_timer_load),
    .load_us(sls_timer_value),
    .done(sls_timer_done)
  );

  // Limited-increment switch-off delay timer
  dsism_us_timer u_sli_timer (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .load(sli_timer_load),
    .load_us(config_in.off_delay_us),
    .done(sli_timer_done)
  );

  dsism_abs_compare #(
    .WIDTH(32)
  ) u_sls_compare (
    .value(encoder.speed),
    .limit(config_in.speed_limit[sls_limit_index]),
    .exceeds(sls_over)
  );

  dsism_abs_compare #(
    .WIDTH(32)
  ) u_sms_compare (
    .value(encoder.speed),
    .limit(config_in.max_speed_limit),
    .exceeds(sms_over)
  );

  dsism_abs_compare #(
    .WIDTH(32)
  ) u_standstill_compare (
    .value(encoder.speed),
    .limit(config_in.standstill_tolerance),
    .exceeds(standstill_over)
  );

  // While enforcing, a new limit choice applies in the cycle it is made
  assign sls_limit_index = (sls_state == SLS_ENFORCE) ? request.limit_select
    : sls_select;

  // Travel from the captured origin, one bit wider to avoid wrap
  assign travel = 33'(encoder.position) - 33'(origin);

  dsism_abs_compare #(
    .WIDTH(33)
  ) u_window_compare (
    .value(travel),
    .limit(config_in.increment_size),
    .exceeds(window_over)
  );

  // Limited-speed function.
  // The slope generator for ramp supervision is not part of this block;
  // with either setting of the mode bit only elapsed time is supervised
  // during the stopping phase, so no slope check can trip here.
  always_comb begin
    next_sls_state = sls_state;
    next_sls_select = sls_select;
    sls_timer_load = 1'b0;
    sls_timer_value = config_in.request_delay_us;
    case (sls_state)
      SLS_IDLE: begin
        if (request.limited_speed_request) begin
          next_sls_select = request.limit_select;
          sls_timer_load = 1'b1;
          sls_timer_value = config_in.request_delay_us;
          next_sls_state = SLS_DELAY;
        end
      end
      SLS_DELAY: begin
        if (sls_timer_done) begin
          sls_timer_load = 1'b1;
          sls_timer_value = config_in.monitor_time_us[sls_select];
          next_sls_state = SLS_MONITOR_TIME;
        end
      end
      SLS_MONITOR_TIME: begin
        if (sls_timer_done) begin
          next_sls_state = SLS_ENFORCE;
        end
      end
      SLS_ENFORCE: begin
        // A new limit choice takes effect at once while enforcing
        next_sls_select = request.limit_select;
      end
      default: begin
        next_sls_state = SLS_IDLE;
      end
    endcase
    if (!request.limited_speed_request) begin
      next_sls_state = SLS_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sls_state <= SLS_IDLE;
      sls_select <= 2'h0;
    end else if (ce) begin
      sls_state <= next_sls_state;
      sls_select <= next_sls_select;
    end
  end

  // Limited-increment function.
  // The window origin is kept across a re-request during the off-delay,
  // so repeated short requests cannot walk the axis away step by step.
  always_comb begin
    next_sli_state = sli_state;
    next_origin = origin;
    sli_timer_load = 1'b0;
    case (sli_state)
      SLI_IDLE: begin
        if (request.increment_request) begin
          next_origin = encoder.position;
          next_sli_state = SLI_ACTIVE;
        end
      end
      SLI_ACTIVE: begin
        if (!request.increment_request) begin
          sli_timer_load = 1'b1;
          next_sli_state = SLI_OFF_DELAY;
        end
      end
      SLI_OFF_DELAY: begin
        if (request.increment_request) begin
          next_sli_state = SLI_ACTIVE;
        end else if (sli_timer_done) begin
          next_sli_state = SLI_IDLE;
        end
      end
      default: begin
        next_sli_state = SLI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sli_state <= SLI_IDLE;
      origin <= RESET_ORIGIN;
    end else if (ce) begin
      sli_state <= next_sli_state;
      origin <= next_origin;
    end
  end

  // Violations, evaluated every cycle
  always_comb begin
    sls_violation = (sls_state == SLS_ENFORCE) && sls_over;
    sms_violation = 1'b0;
    if (config_in.max_speed_used) begin
      sms_violation = sms_over || encoder_bad;
    end
    sli_violation = 1'b0;
    if (sli_state == SLI_IDLE) begin
      if (request.increment_request) begin
        sli_violation = standstill_over || encoder_bad;
      end
    end else begin
      sli_violation = window_over || encoder_bad;
    end
    any_violation = sls_violation || sms_violation || sli_violation;
  end

  // Fail-safe latch: a violation in the acknowledge cycle keeps it set
  assign ack_edge = request.error_ack && !ack_prev;

  always_comb begin
    next_ack_prev = request.error_ack;
    next_fail_safe = fail_safe;
    if (ack_edge) begin
      next_fail_safe = 1'b0;
    end
    if (any_violation) begin
      next_fail_safe = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fail_safe <= RESET_FAIL_SAFE;
      ack_prev <= 1'b0;
    end else if (ce) begin
      fail_safe <= next_fail_safe;
      ack_prev <= next_ack_prev;
    end
  end

  // Status bits.
  // Safe-state bits drop while the drive is in fail-safe: with torque off
  // no function can claim its limit is being held under supervision.
  always_comb begin
    next_status.limited_speed_safe = (next_sls_state == SLS_ENFORCE)
      && !next_fail_safe;
    next_status.max_speed_safe = config_in.max_speed_used
      && !sms_violation && !next_fail_safe;
    next_status.increment_safe = (next_sli_state != SLI_IDLE)
      && !sli_violation && !next_fail_safe;
    next_status.function_no_error_out = !next_fail_safe;
    next_status.torque_enable = !next_fail_safe;
    next_status.fail_safe = next_fail_safe;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status.limited_speed_safe <= 1'b0;
      status.max_speed_safe <= 1'b0;
      status.increment_safe <= 1'b0;
      status.function_no_error_out <= !RESET_FAIL_SAFE;
      status.torque_enable <= !RESET_FAIL_SAFE;
      status.fail_safe <= RESET_FAIL_SAFE;
    end else if (ce) begin
      status <= next_status;
    end
  end

endmodule : dsism_monitor

//--- dsism_monitor_chk.sv
/*
  Assertions on the ports of the speed / increment safety monitor.
  Assumes it is bound to dsism_monitor on one clock domain.
*/
`timescale 1ns/1ps
module dsism_monitor_chk
  import dsism_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire dsism_config_type config_in, // Safety parameters
  input wire dsism_encoder_type encoder, // Encoder feedback
  input wire dsism_request_type request, // Requests
  input wire dsism_status_type status // Monitor outputs
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  int sls_cnt;
  int sls_lim;

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction : mag

  // Cycles a held request may take before its limit must be enforced
  assign sls_lim = CYCLES_PER_US * int'(config_in.request_delay_us
    + config_in.monitor_time_us[request.limit_select]) + 4;

  always_ff @(posedge clk) begin
    if (!reset_n || !request.limited_speed_request || status.fail_safe) begin
      sls_cnt <= 0;
    end else if (ce) begin
      sls_cnt <= sls_cnt + 1;
    end
  end

  drive_off_a: assert property (status.fail_safe |->
    !status.torque_enable && !status.function_no_error_out)
    else $error("fail-safe without torque and no-error drop");
  safe_drop_a: assert property (status.fail_safe |->
    !(status.limited_speed_safe || status.max_speed_safe
    || status.increment_safe))
    else $error("safe bit high in fail-safe");
  max_trip_a: assert property (ce && config_in.max_speed_used
    && mag(encoder.speed) > config_in.max_speed_limit |=> status.fail_safe)
    else $error("overspeed not latched");
  enc_loss_a: assert property (ce && config_in.max_speed_used
    && (!encoder.present || encoder.fault) |=> status.fail_safe)
    else $error("encoder loss not latched");
  fail_hold_a: assert property (status.fail_safe
    && !request.error_ack |=> status.fail_safe)
    else $error("fail-safe cleared without acknowledge");
  still_chk_a: assert property (ce && $rose(request.increment_request)
    && !status.increment_safe
    && mag(encoder.speed) > config_in.standstill_tolerance
    |=> status.fail_safe)
    else $error("moving axis accepted at increment request");
  inc_arm_a: assert property ($rose(status.increment_safe)
    |-> $past(request.increment_request))
    else $error("increment safe without request");
  sls_early_a: assert property (ce
    && $rose(request.limited_speed_request) && !status.limited_speed_safe
    |-> !status.limited_speed_safe [*3])
    else $error("limited speed safe too early");
  sls_reach_a: assert property (sls_cnt == sls_lim
    |-> status.limited_speed_safe)
    else $error("limited speed not enforced in time");
  sls_trip_a: assert property (ce && status.limited_speed_safe
    && request.limited_speed_request
    && mag(encoder.speed) > config_in.speed_limit[request.limit_select]
    |=> status.fail_safe)
    else $error("limited speed violation not latched");
endmodule : dsism_monitor_chk

//--- dsism_drive_model.sv
/*
  Drive application and safe encoder model: speed follows the command at
  a bounded rate, position integrates speed. Assumes tb commands it.
*/
`timescale 1ns/1ps
module dsism_drive_model
  import dsism_pkg::*;
#(
  parameter int STEP = 10
) (
  input wire logic clk, // System clock
  input wire logic signed [31:0] target, // Commanded speed
  input wire logic present, // Encoder found
  input wire logic fault, // Encoder fault
  output dsism_encoder_type encoder // Feedback to monitor
);
  logic signed [31:0] spd = 32'sh0;
  logic signed [31:0] pos = 32'sh0;

  // Bounded rate, so a stop takes real time as on a drive
  always @(posedge clk) begin
    if (target - spd > STEP) begin
      spd <= spd + STEP;
    end else if (spd - target > STEP) begin
      spd <= spd - STEP;
    end else begin
      spd <= target;
    end
    pos <= pos + spd;
  end

  // A missing encoder leaves stale lines; show their inverse
  assign encoder = '{speed: present ? spd : ~spd,
    position: present ? pos : ~pos, present: present, fault: fault};
endmodule : dsism_drive_model

//--- tb.sv
/*
  Self-checking bench for the speed / increment safety monitor.
  Assumes the drive model and checker are compiled before it.
*/
`timescale 1ns/1ps
module tb;
  import dsism_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic present = 1'b1;
  logic fault = 1'b0;
  logic signed [31:0] target = 32'sh0;
  integer seed = 32'hc80cc491;
  int errors = 0;
  int cmp_count = 0;
  dsism_config_type cfg;
  dsism_encoder_type enc;
  dsism_request_type req = '0;
  dsism_status_type status;
  dsism_status_type exp_q[$];
  dsism_status_type e;

  dsism_drive_model dsism_drive_model_inst (.clk(clk), .target(target),
    .present(present), .fault(fault), .encoder(enc));
  dsism_monitor dsism_monitor_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
    .config_in(cfg), .encoder(enc), .request(req), .status(status));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Note the status expected after the latest edge
  task automatic expect_st(input logic [5:0] s);
    exp_q.push_back(dsism_status_type'(s));
    @(posedge clk);
  endtask : expect_st

  // Drive settles to rest and any off-delay runs out before acknowledge
  task automatic ack();
    req <= '0;
    target <= 32'sh0;
    present <= 1'b1;
    fault <= 1'b0;
    tick(120);
    req.error_ack <= 1'b1;
    tick(1);
    req.error_ack <= 1'b0;
    tick(2);
  endtask : ack

  task automatic conclude();
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  always @(negedge clk) begin
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      cmp_count++;
      if (status !== e) begin
        errors++;
        $display("ERROR %0t: status %h, expected %h", $time, status, e);
      end
    end
  end

  initial begin
    #(CLK_PERIOD_NS * 20000);
    errors++;
    conclude();
  end

  initial begin
    int sp;
    cfg = '0;
    cfg.max_speed_used = 1'b1;
    cfg.max_speed_limit = 32'h3e8;
    for (int i = 0; i < LIMIT_COUNT; i++) begin
      cfg.speed_limit[i] = 32'(100 * (i + 2));
      cfg.monitor_time_us[i] = 32'(i + 1);
    end
    cfg.request_delay_us = 32'h1;
    cfg.standstill_tolerance = 32'h2;
    cfg.increment_size = 32'h5;
    cfg.off_delay_us = 32'h1;
    tick(2);
    expect_st(6'h06);
    reset_n <= 1'b1;
    tick(1);
    expect_st(6'h16);
    repeat (8) begin
      sp = $random(seed) % 1000;
      target <= sp;
      tick(210);
      expect_st(6'h16);
    end
    target <= 32'sh3f2;
    tick(220);
    expect_st(6'h01);
    target <= 32'sh0;
    tick(120);
    expect_st(6'h01);
    ack();
    expect_st(6'h16);
    fault <= 1'b1;
    tick(2);
    expect_st(6'h01);
    ack();
    expect_st(6'h16);
    // Clock enable low must freeze the status although the encoder fails
    ce <= 1'b0;
    fault <= 1'b1;
    tick(3);
    expect_st(6'h16);
    ce <= 1'b1;
    tick(2);
    expect_st(6'h01);
    ack();
    expect_st(6'h16);
    // Limits 200..500: cruising at 450 breaks all but the last
    for (int s = 0; s < LIMIT_COUNT; s++) begin
      target <= 32'sh1c2;
      tick(60);
      req.limit_select <= 2'(s);
      req.limited_speed_request <= 1'b1;
      target <= 32'sh64;
      tick(2);
      expect_st(6'h16);
      tick(CYCLES_PER_US * (2 + s) + 4);
      expect_st(6'h36);
      target <= 32'sh1c2;
      tick(60);
      expect_st(s == 3 ? 6'h36 : 6'h01);
      ack();
      expect_st(6'h16);
    end
    req.increment_request <= 1'b1;
    tick(2);
    expect_st(6'h1e);
    req.increment_request <= 1'b0;
    tick(3);
    expect_st(6'h1e);
    tick(CYCLES_PER_US + 4);
    expect_st(6'h16);
    req.increment_request <= 1'b1;
    tick(2);
    target <= 32'sh1;
    tick(3);
    expect_st(6'h1e);
    tick(10);
    expect_st(6'h01);
    ack();
    expect_st(6'h16);
    target <= 32'sh3;
    tick(5);
    req.increment_request <= 1'b1;
    tick(2);
    expect_st(6'h01);
    ack();
    expect_st(6'h16);
    cfg.max_speed_used <= 1'b0;
    tick(2);
    expect_st(6'h06);
    present <= 1'b0;
    tick(3);
    expect_st(6'h06);
    req.increment_request <= 1'b1;
    tick(2);
    expect_st(6'h01);
    ack();
    expect_st(6'h06);
    conclude();
  end
endmodule : tb

bind dsism_monitor dsism_monitor_chk dsism_monitor_chk_inst (.clk(clk),
  .reset_n(reset_n), .ce(ce), .config_in(config_in), .encoder(encoder),
  .request(request), .status(status));
